/* core/abvi_core.sv */
// How it works
// - Data path reads busy during purge flush
// - Error flag aborts path transfers until cleared
// - Purge of an empty path does nothing
// - Purge of direct path zero ignored
// - Four peripheral levels, adapter on jumper level
// - One vector register per level four..seven
// - Vector in low bits, bit 31 adapter
// - Forward requests only with both enables set
// - Grant when request, empty, power good
// - Captured vector returned with adapter bit
// - Failed conditions return stored contents or zero
// - Full clears only on ack or init
// - No grant while adapter interrupt pending
// - Raise backplane request, answer summary sublevel
// - Passive release loads no vector
// - Adapter request holds until status cleared
// - Window of sixteen 512-byte pages
// - Flush writes, clears not-empty, error on fail
`timescale 1ns/1ns
module abvi_core
   import abvi_pkg::*;
#(
   parameter logic [SUB_W-1:0] SUBLEVEL = 4'h1
)
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 adapter_init,
   // Control and status
   input  wire logic                 interrupt_fielder_switch,
   input  wire logic                 request_interrupt_enable,
   input  wire logic                 adapter_int_enable,
   input  wire logic                 adapter_status_pending,
   input  wire logic [LVL_W-1:0]     adapter_level,
   input  wire logic [PATH_W-1:0]    xfer_req_num,
   // Peripheral bus side
   input  wire logic [LEVELS-1:0]    peripheral_request_line,
   input  wire logic                 power_low_warning,
   input  wire logic                 vec_strobe,
   input  wire logic [VEC_W-1:0]     vec_data,
   input  wire logic                 passive_release,
   output logic [LEVELS-1:0]         grant_ff,
   // Backplane interrupt side
   output logic [LEVELS-1:0]         bp_request_ff,
   input  wire abvi_lvl_cmd_t        summary_cmd,
   output abvi_sum_rsp_t             summary_rsp_ff,
   input  wire abvi_lvl_cmd_t        vector_cmd,
   output abvi_rd_rsp_t              vector_rsp_ff,
   input  wire logic                 vector_ack,
   // Data path registers
   input  wire logic [PATH_W-1:0]    dp_sel,
   input  wire logic                 dp_purge_wr,
   input  wire logic                 dp_bte_clr_wr,
   input  wire logic                 dp_rd,
   output abvi_rd_rsp_t              dp_rsp_ff,
   output logic                      dp_busy_ff,
   input  wire logic [NUM_PATHS-1:0] path_fill,
   input  wire logic [NUM_PATHS-1:0] path_write_mode,
   input  wire logic                 flush_fail,
   output logic [NUM_PATHS-1:0]      path_abort_ff,
   output logic                      flush_active_ff,
   // Register window
   input  wire logic [31:0]          probe_addr,
   output logic [31:0]               win_base_ff,
   output logic                      probe_hit_ff
);
   // ***************************************************************
   // Adapter interrupt and backplane requests
   // ***************************************************************
   logic                 adp_int;
   logic                 fwd_en;
   logic [LEVELS-1:0]    nxt_bp_request;
   assign adp_int = adapter_int_enable & adapter_status_pending;
   assign fwd_en  = interrupt_fielder_switch & request_interrupt_enable;
   genvar gl;
   generate
      for (gl = 0; gl < LEVELS; gl++)
      begin : g_req
         assign nxt_bp_request[gl] = (fwd_en & peripheral_request_line[gl])
                                   | (adp_int & (adapter_level == LVL_W'(gl)));
      end
   endgenerate
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         bp_request_ff <= '0;
      else if (adapter_init)
         bp_request_ff <= '0;
      else
         bp_request_ff <= nxt_bp_request;
   end
   // Sublevel only answered for a level we are actually requesting
   abvi_sum_rsp_t nxt_summary_rsp;
   assign nxt_summary_rsp.valid    = summary_cmd.req;
   assign nxt_summary_rsp.sublevel = (summary_cmd.req & bp_request_ff[summary_cmd.level])
                                     ? SUBLEVEL : '0;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         summary_rsp_ff <= '0;
      else
         summary_rsp_ff <= nxt_summary_rsp;
   end
   // ***************************************************************
   // Vector fetch
   // ***************************************************************
   abvi_vst_t            vst_ff;
   abvi_vst_t            nxt_vst;
   logic [LVL_W-1:0]     vlvl_ff;
   logic [LVL_W-1:0]     ack_lvl_ff;
   logic [VEC_W-1:0]     vec_ff [LEVELS];
   logic [LEVELS-1:0]    full_ff;
   logic                 grant_ok;
   logic                 load_vec;
   // Adapter pending blocks the grant; bit 31 then tells software why
   assign grant_ok = peripheral_request_line[vector_cmd.level]
                   & ~full_ff[vector_cmd.level]
                   & ~power_low_warning
                   & ~adp_int;
   assign load_vec = (vst_ff == VST_GRANT) & vec_strobe;
   always_comb
   begin
      nxt_vst = vst_ff;
      case (vst_ff)
         VST_IDLE:
            if (vector_cmd.req)
               nxt_vst = grant_ok ? VST_GRANT : VST_ANSWER;
         VST_GRANT:
            if (vec_strobe || passive_release)
               nxt_vst = VST_ANSWER;
         VST_ANSWER:
            nxt_vst = VST_IDLE;
         default:
            nxt_vst = VST_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vst_ff  <= VST_IDLE;
         vlvl_ff <= '0;
      end
      else if (adapter_init)
         vst_ff  <= VST_IDLE;
      else
      begin
         vst_ff <= nxt_vst;
         if (vst_ff == VST_IDLE && vector_cmd.req)
            vlvl_ff <= vector_cmd.level;
      end
   end
   generate
      for (gl = 0; gl < LEVELS; gl++)
      begin : g_vec
         logic sel_lvl;
         logic ack_hit;
         assign sel_lvl = (vlvl_ff == LVL_W'(gl));
         assign ack_hit = vector_ack & (ack_lvl_ff == LVL_W'(gl));
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               full_ff[gl] <= 1'b0;
               vec_ff[gl]  <= '0;
            end
            else if (adapter_init)
            begin
               full_ff[gl] <= 1'b0;
               vec_ff[gl]  <= '0;
            end
            else if (load_vec && sel_lvl)
            begin
               full_ff[gl] <= 1'b1;
               vec_ff[gl]  <= vec_data;
            end
            else if (ack_hit)
            begin
               full_ff[gl] <= 1'b0;
               vec_ff[gl]  <= '0;
            end
         end
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               grant_ff[gl] <= 1'b0;
            else if (adapter_init)
               grant_ff[gl] <= 1'b0;
            else
               grant_ff[gl] <= (nxt_vst == VST_GRANT) &
                               ((vst_ff == VST_IDLE) ? (vector_cmd.level == LVL_W'(gl))
                                                     : sel_lvl);
         end
      end
   endgenerate
   abvi_rd_rsp_t nxt_vector_rsp;
   always_comb
   begin
      nxt_vector_rsp                       = '0;
      nxt_vector_rsp.valid                 = (vst_ff == VST_ANSWER);
      nxt_vector_rsp.data[VEC_W-1:0]       = vec_ff[vlvl_ff];
      nxt_vector_rsp.data[ADP_SERVICE_BIT] = adp_int;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vector_rsp_ff <= '0;
         ack_lvl_ff    <= '0;
      end
      else
      begin
         vector_rsp_ff <= nxt_vector_rsp;
         if (vst_ff == VST_ANSWER)
            ack_lvl_ff <= vlvl_ff;
      end
   end
   // ***************************************************************
   // Buffered path purge
   // ***************************************************************
   logic [NUM_PATHS-1:0] bne_ff;
   logic [PATH_W-1:0]    flush_path_ff;
   logic [CNT_W-1:0]     flush_cnt_ff;
   logic                 purge_req;
   logic                 flush_start;
   logic                 flush_done;
   // Purges during a flush are dropped: only one flush engine
   assign purge_req   = dp_purge_wr & (dp_sel != '0) & bne_ff[dp_sel]
                      & ~flush_active_ff;
   assign flush_start = purge_req & path_write_mode[dp_sel];
   assign flush_done  = flush_active_ff & (flush_cnt_ff == '0);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flush_active_ff <= 1'b0;
         flush_path_ff   <= '0;
         flush_cnt_ff    <= '0;
      end
      else if (adapter_init)
         flush_active_ff <= 1'b0;
      else if (flush_start)
      begin
         flush_active_ff <= 1'b1;
         flush_path_ff   <= dp_sel;
         flush_cnt_ff    <= CNT_W'(PURGE_CYCLES - 1);
      end
      else if (flush_done)
         flush_active_ff <= 1'b0;
      else if (flush_active_ff)
         flush_cnt_ff    <= flush_cnt_ff - 1'b1;
   end
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PATHS; gp++)
      begin : g_path
         logic here;
         logic bne_set;
         logic bne_clr;
         logic bte_set;
         logic bte_clr;
         assign here    = (dp_sel == PATH_W'(gp));
         assign bne_set = path_fill[gp] & (gp != 0);
         assign bne_clr = (purge_req & here & ~path_write_mode[gp])
                        | (flush_done & (flush_path_ff == PATH_W'(gp)));
         assign bte_set = flush_done & flush_fail & (flush_path_ff == PATH_W'(gp));
         assign bte_clr = dp_bte_clr_wr & here;
         // Fill and error set win over a clear in the same cycle
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               bne_ff[gp] <= 1'b0;
            else if (bne_set)
               bne_ff[gp] <= 1'b1;
            else if (adapter_init || bne_clr)
               bne_ff[gp] <= 1'b0;
         end
         // Purge never clears the error flag; a failed flush sets it
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               path_abort_ff[gp] <= 1'b0;
            else if (bte_set)
               path_abort_ff[gp] <= 1'b1;
            else if (bte_clr)
               path_abort_ff[gp] <= 1'b0;
         end
      end
   endgenerate
   abvi_rd_rsp_t nxt_dp_rsp;
   always_comb
   begin
      nxt_dp_rsp                    = '0;
      nxt_dp_rsp.valid              = dp_rd & ~flush_active_ff;
      // Busy answer carries no data, so no stale flag is seen as read
      nxt_dp_rsp.data[DP_BNE_BIT]   = nxt_dp_rsp.valid & bne_ff[dp_sel];
      nxt_dp_rsp.data[DP_WMODE_BIT] = nxt_dp_rsp.valid & path_write_mode[dp_sel];
      nxt_dp_rsp.data[DP_BTE_BIT]   = nxt_dp_rsp.valid & path_abort_ff[dp_sel];
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dp_rsp_ff  <= '0;
         dp_busy_ff <= 1'b0;
      end
      else
      begin
         dp_rsp_ff  <= nxt_dp_rsp;
         dp_busy_ff <= dp_rd & flush_active_ff;
      end
   end
   // ***************************************************************
   // Register window decode
   // ***************************************************************
   logic [31:0] nxt_win_base;
   assign nxt_win_base = WIN_PHYS_BASE + (32'(xfer_req_num) << WIN_SHIFT);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         win_base_ff  <= '0;
         probe_hit_ff <= 1'b0;
      end
      else
      begin
         win_base_ff  <= nxt_win_base;
         probe_hit_ff <= (probe_addr[31:WIN_SHIFT] == nxt_win_base[31:WIN_SHIFT]);
      end
   end
endmodule : abvi_core

/* core/abvi_pkg.sv */
package abvi_pkg;

   // ***************************************************************
   // Sizes
   // ***************************************************************
   localparam int LEVELS      = 4;
   localparam int LVL_W       = 2;
   localparam int LEVEL_BASE  = 4;
   localparam int NUM_PATHS   = 16;
   localparam int PATH_W      = 4;
   localparam int VEC_W       = 16;
   localparam int DATA_W      = 32;
   localparam int SUB_W       = 4;

   // ***************************************************************
   // Read data layouts
   // ***************************************************************
   localparam int ADP_SERVICE_BIT = 31;
   localparam int DP_BNE_BIT      = 0;
   localparam int DP_WMODE_BIT    = 1;
   localparam int DP_BTE_BIT      = 2;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int PURGE_TIME_NS = 2000;
   localparam int PURGE_CYCLES  = (PURGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 8;

   // ***************************************************************
   // Register window
   // ***************************************************************
   localparam int             WIN_PAGES     = 16;
   localparam int             PAGE_BYTES    = 512;
   localparam int             WIN_BYTES     = WIN_PAGES * PAGE_BYTES;
   localparam int             WIN_SHIFT     = $clog2(WIN_BYTES);
   localparam logic [31:0]    WIN_PHYS_BASE = 32'h2000_0000;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      VST_IDLE   = 2'b00,
      VST_GRANT  = 2'b01,
      VST_ANSWER = 2'b11
   } abvi_vst_t;

   typedef struct packed {
      logic             req;
      logic [LVL_W-1:0] level;
   } abvi_lvl_cmd_t;

   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] data;
   } abvi_rd_rsp_t;

   typedef struct packed {
      logic             valid;
      logic [SUB_W-1:0] sublevel;
   } abvi_sum_rsp_t;

endpackage : abvi_pkg

/* dv/abvi_core_sva.sv */
`timescale 1ns/1ns
module abvi_core_sva
   import abvi_pkg::*;
#(
   parameter logic [SUB_W-1:0] SUBLEVEL = 4'h1
)
(
   // Clock and controls
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire logic                 adapter_init,
   input wire logic                 interrupt_fielder_switch,
   input wire logic                 request_interrupt_enable,
   input wire logic                 adapter_int_enable,
   input wire logic                 adapter_status_pending,
   input wire logic [LVL_W-1:0]     adapter_level,
   // Interrupt side
   input wire logic [LEVELS-1:0]    peripheral_request_line,
   input wire logic [LEVELS-1:0]    bp_request_ff,
   input wire logic                 power_low_warning,
   input wire logic                 vec_strobe,
   input wire logic [VEC_W-1:0]     vec_data,
   input wire logic [LEVELS-1:0]    grant_ff,
   input wire abvi_lvl_cmd_t        summary_cmd,
   input wire abvi_sum_rsp_t        summary_rsp_ff,
   input wire abvi_lvl_cmd_t        vector_cmd,
   input wire abvi_rd_rsp_t         vector_rsp_ff,
   // Data paths
   input wire logic                 dp_rd,
   input wire logic                 dp_bte_clr_wr,
   input wire abvi_rd_rsp_t         dp_rsp_ff,
   input wire logic                 dp_busy_ff,
   input wire logic                 flush_active_ff,
   input wire logic [NUM_PATHS-1:0] path_abort_ff
);
   // ********
   // Checks
   // ********
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   wire logic adp_act = adapter_int_enable & adapter_status_pending;
   wire logic [LEVELS-1:0] fwd_exp =
      ({LEVELS{interrupt_fielder_switch & request_interrupt_enable}} & peripheral_request_line)
      | ({LEVELS{adp_act}} & (4'h1 << adapter_level));

   sequence s_blocked;
      vector_cmd.req && (power_low_warning || adp_act || !peripheral_request_line[vector_cmd.level]);
   endsequence
   sequence s_strobe;
      (|grant_ff) && vec_strobe;
   endsequence
   sequence s_flush_run;
      flush_active_ff [*8] ##42 flush_active_ff ##1 !flush_active_ff;
   endsequence

   property p_fwd;
      !adapter_init |=> bp_request_ff == $past(fwd_exp);
   endproperty
   a_fwd: assert property (p_fwd) else $error("backplane request wrong");

   property p_sum;
      summary_cmd.req |=> summary_rsp_ff.valid && summary_rsp_ff.sublevel ==
         ($past(bp_request_ff[summary_cmd.level]) ? SUBLEVEL : 4'h0);
   endproperty
   a_sum: assert property (p_sum) else $error("summary answer wrong");

   property p_block;
      s_blocked |-> ##1 (grant_ff == 4'h0) ##1 vector_rsp_ff.valid;
   endproperty
   a_block: assert property (p_block) else $error("grant despite blocking");

   property p_vec;
      s_strobe |-> ##2 vector_rsp_ff.valid && vector_rsp_ff.data[15:0] == $past(vec_data, 2);
   endproperty
   a_vec: assert property (p_vec) else $error("captured vector lost");

   property p_bit31;
      vector_rsp_ff.valid |-> vector_rsp_ff.data[31:16] == {$past(adp_act), 15'h0000};
   endproperty
   a_bit31: assert property (p_bit31) else $error("vector upper bits wrong");

   property p_dprd;
      dp_rd |=> dp_busy_ff == $past(flush_active_ff) && dp_rsp_ff.valid != $past(flush_active_ff);
   endproperty
   a_dprd: assert property (p_dprd) else $error("busy answer wrong");

   property p_flush;
      $rose(flush_active_ff) |-> s_flush_run;
   endproperty
   a_flush: assert property (p_flush) else $error("flush length wrong");

   property p_bte;
      !dp_bte_clr_wr |=> ($past(path_abort_ff) & ~path_abort_ff) == 16'h0000;
   endproperty
   a_bte: assert property (p_bte) else $error("error flag fell");
endmodule : abvi_core_sva

bind abvi_core abvi_core_sva #(.SUBLEVEL(SUBLEVEL)) i_sva
(
   .clk, .rst_n, .adapter_init, .interrupt_fielder_switch, .request_interrupt_enable,
   .adapter_int_enable, .adapter_status_pending, .adapter_level, .peripheral_request_line,
   .bp_request_ff, .power_low_warning, .vec_strobe, .vec_data, .grant_ff, .summary_cmd,
   .summary_rsp_ff, .vector_cmd, .vector_rsp_ff, .dp_rd, .dp_bte_clr_wr, .dp_rsp_ff,
   .dp_busy_ff, .flush_active_ff, .path_abort_ff
);

/* dv/abvi_periph.sv */
`timescale 1ns/1ns
module abvi_periph
   import abvi_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Grant in, answer out
   input  wire logic [LEVELS-1:0] grant_ff,
   input  wire logic [3:0]        dly,
   input  wire logic              drop,
   input  wire logic [VEC_W-1:0]  vec_val,
   output logic                   vec_strobe,
   output logic                   passive_release,
   output logic [VEC_W-1:0]       vec_data
);
   // ********
   // Device answering a grant
   // ********
   logic [3:0] cnt_ff;
   wire  logic fire = (|grant_ff) && (cnt_ff == dly);

   // Idle data toggles, so a stale vector never looks captured
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_ff          <= 4'h0;
         vec_strobe      <= 1'b0;
         passive_release <= 1'b0;
         vec_data        <= 16'h0000;
      end
      else
      begin
         vec_strobe      <= fire && !drop;
         passive_release <= fire && drop;
         vec_data        <= fire ? vec_val : ~vec_data;
         cnt_ff          <= !(|grant_ff) ? 4'h0 : (cnt_ff > dly) ? cnt_ff : cnt_ff + 4'h1;
      end
   end
endmodule : abvi_periph

/* dv/test_bus_adapter_interrupt_vectoring.sv */
`timescale 1ns/1ns
module test_bus_adapter_interrupt_vectoring
   import abvi_pkg::*;
   ;
   localparam logic [SUB_W-1:0] SUB = 4'h9;
   logic clk, rst_n, adapter_init, interrupt_fielder_switch, request_interrupt_enable;
   logic adapter_int_enable, adapter_status_pending, power_low_warning, vector_ack, drop;
   logic vec_strobe, passive_release, dp_purge_wr, dp_bte_clr_wr, dp_rd, flush_fail;
   logic flush_active_ff, dp_busy_ff, probe_hit_ff;
   logic [1:0] adapter_level;
   logic [3:0] xfer_req_num, dp_sel, dly, peripheral_request_line, grant_ff, bp_request_ff;
   logic [15:0] vec_data, vec_val, path_fill, path_write_mode, path_abort_ff;
   logic [31:0] probe_addr, win_base_ff;
   abvi_lvl_cmd_t summary_cmd, vector_cmd;
   abvi_sum_rsp_t summary_rsp_ff;
   abvi_rd_rsp_t  vector_rsp_ff, dp_rsp_ff;
   int num_errors = 0;
   int comparisons = 0;

   abvi_core #(.SUBLEVEL(SUB)) i_dut
   (
      .clk, .rst_n, .adapter_init, .interrupt_fielder_switch, .request_interrupt_enable,
      .adapter_int_enable, .adapter_status_pending, .adapter_level, .xfer_req_num,
      .peripheral_request_line, .power_low_warning, .vec_strobe, .vec_data, .passive_release,
      .grant_ff, .bp_request_ff, .summary_cmd, .summary_rsp_ff, .vector_cmd, .vector_rsp_ff,
      .vector_ack, .dp_sel, .dp_purge_wr, .dp_bte_clr_wr, .dp_rd, .dp_rsp_ff, .dp_busy_ff,
      .path_fill, .path_write_mode, .flush_fail, .path_abort_ff, .flush_active_ff,
      .probe_addr, .win_base_ff, .probe_hit_ff
   );
   abvi_periph i_dev (.clk, .rst_n, .grant_ff, .dly, .drop, .vec_val, .vec_strobe,
                      .passive_release, .vec_data);

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ********
   // Helpers
   // ********
   function automatic logic [3:0] fwd_exp();
      return ({4{interrupt_fielder_switch & request_interrupt_enable}} & peripheral_request_line)
           | ({4{adapter_int_enable & adapter_status_pending}} & (4'h1 << adapter_level));
   endfunction : fwd_exp

   task complete_run;
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task guard(input int n);
      if (n >= 60)
      begin
         chk("wait_bound", 32'h0, 32'h1);
         complete_run();
      end
   endtask : guard

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse

   // Waits out a slow device, never longer than the bound
   task vread(input logic [1:0] l, output logic [31:0] d);
      int n;
      vector_cmd = '{1'b1, l};
      @(negedge clk);
      vector_cmd = '0;
      for (n = 0; n < 60 && vector_rsp_ff.valid !== 1'b1; n++)
         @(negedge clk);
      guard(n);
      d = vector_rsp_ff.data;
      @(negedge clk);
   endtask : vread

   // Busy, valid and layout bits folded into one word
   task dprd(input logic [3:0] p, input logic [31:0] e);
      dp_sel = p;
      pulse(dp_rd);
      chk("dp_read", e, {dp_busy_ff, dp_rsp_ff.valid, dp_rsp_ff.data[29:0]});
      @(negedge clk);
   endtask : dprd

   // ********
   // Stimulus
   // ********
   initial
   begin
      logic [31:0] d;
      logic [15:0] v;
      int n;
      int pl[3];
      {rst_n, adapter_init, interrupt_fielder_switch, request_interrupt_enable, dp_sel,
       adapter_int_enable, adapter_status_pending, adapter_level, xfer_req_num} = '0;
      {peripheral_request_line, power_low_warning, vector_ack, dp_purge_wr, drop} = '0;
      {dp_bte_clr_wr, dp_rd, path_fill, path_write_mode, flush_fail, probe_addr} = '0;
      {summary_cmd, vector_cmd, dly, vec_val} = '0;
      pl = '{0, 3, 5};
      n = $urandom(32'h9ee2);
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         xfer_req_num = 4'($urandom);
         d = 32'h2000_0000 + {15'h0000, xfer_req_num, 13'h0000};
         probe_addr = d + (i[0] ? 32'h0000_1ffc : 32'h0000_2000);
         repeat (2) @(negedge clk);
         chk("win_base", d, win_base_ff);
         chk("probe_hit", 32'(i[0]), {31'h0, probe_hit_ff});
      end
      for (int i = 0; i < 24; i++)
      begin
         {interrupt_fielder_switch, request_interrupt_enable, adapter_int_enable,
          adapter_status_pending, adapter_level, peripheral_request_line} = 10'($urandom);
         @(negedge clk);
         chk("bp_request", {28'h0, fwd_exp()}, {28'h0, bp_request_ff});
         summary_cmd = '{1'b1, 2'(i)};
         @(negedge clk);
         summary_cmd = '0;
         d = {27'h0, 1'b1, fwd_exp() >> i[1:0] & 4'h1 ? SUB : 4'h0};
         chk("summary", d, {27'h0, summary_rsp_ff});
      end
      {interrupt_fielder_switch, request_interrupt_enable, adapter_int_enable,
       adapter_status_pending, adapter_level, peripheral_request_line} = 10'h30f;
      for (int l = 0; l < 4; l++)
      begin
         v = 16'($urandom) | 16'h0001;
         vec_val = v;
         dly = 4'($urandom_range(3));
         drop = 1'b0;
         vread(2'(l), d);
         chk("vec_grant", {16'h0000, v}, d);
         vread(2'(l), d);
         chk("vec_kept", {16'h0000, v}, d);
         {adapter_int_enable, adapter_status_pending} = 2'b11;
         vread(2'(l), d);
         chk("vec_both", {16'h8000, v}, d);
         {adapter_int_enable, adapter_status_pending} = 2'b00;
         pulse(vector_ack);
         drop = 1'b1;
         vread(2'(l), d);
         chk("vec_passive", 32'h0, d);
      end
      for (int c = 0; c < 3; c++)
      begin
         {power_low_warning, adapter_status_pending, adapter_int_enable} = {c == 0, c == 2, c == 2};
         peripheral_request_line = (c == 1) ? 4'hb : 4'hf;
         vread(2'h2, d);
         chk("vec_block", (c == 2) ? 32'h8000_0000 : 32'h0, d);
      end
      {power_low_warning, adapter_status_pending, adapter_int_enable, drop} = 4'h0;
      peripheral_request_line = 4'hf;
      vread(2'h2, d);
      pulse(adapter_init);
      drop = 1'b1;
      vread(2'h2, d);
      chk("vec_init", 32'h0, d);
      path_write_mode = 16'h00a0;
      path_fill = 16'h0009;
      @(negedge clk);
      path_fill = 16'h0000;
      dprd(4'h0, 32'h4000_0000);
      dprd(4'h3, 32'h4000_0001);
      foreach (pl[k])
      begin
         dp_sel = 4'(pl[k]);
         pulse(dp_purge_wr);
         @(negedge clk);
         chk("flush_idle", 32'h0, {31'h0, flush_active_ff});
      end
      dprd(4'h3, 32'h4000_0000);
      for (int f = 0; f < 3; f++)
      begin
         path_fill = 16'h0080;
         flush_fail = (f == 1);
         @(negedge clk);
         path_fill = 16'h0000;
         dp_sel = 4'h7;
         pulse(dp_purge_wr);
         @(negedge clk);
         dprd(4'h7, 32'h8000_0000);
         for (n = 0; n < 60 && flush_active_ff === 1'b1; n++)
            @(negedge clk);
         guard(n);
         @(negedge clk);
         dprd(4'h7, (f > 0) ? 32'h4000_0006 : 32'h4000_0002);
         chk("abort", 32'(f > 0), {31'h0, path_abort_ff[7]});
      end
      dp_sel = 4'h7;
      pulse(dp_bte_clr_wr);
      dprd(4'h7, 32'h4000_0002);
      complete_run();
   end
endmodule : test_bus_adapter_interrupt_vectoring
